// ===== logic/fc_defines.svh
// offsets, field positions, reset values and limits of the config/totalizer block
`ifndef FC_DEFINES_SVH
`define FC_DEFINES_SVH
`define FC_OFS_CTRL 8'h00
`define FC_OFS_ACCESS 8'h04
`define FC_OFS_CODE 8'h08
`define FC_OFS_ADDR 8'h0c
`define FC_OFS_CHAN 8'h10
`define FC_OFS_UNIT 8'h14
`define FC_OFS_STAT 8'h18
`define FC_OFS_TOTAL 8'h1c
`define FC_OFS_BUSUNIT 8'h20
`define FC_CTRL_BIDIR 0
`define FC_CTRL_TMODE_LO 1
`define FC_CTRL_PROFILE 3
`define FC_CTRL_PUSH 4
`define FC_UNIT_KIND_LO 8
`define FC_UNIT_NEWPASS 31
`define FC_RST_CODE 16'h0050
`define FC_RST_ADDR 7'h7e
`define FC_RST_CHAN 16'h0111
`define FC_RST_UNIT 8'h00
`define FC_CHAN_OFF 16'h0000
`define FC_ADDR_MIN 7'h01
`define FC_ADDR_MAX 7'h7e
`endif

// ===== logic/fc_pkg.sv
// types of the config/totalizer block
package fc_pkg;
  typedef enum logic [1:0] {ST_TEST, ST_MEAS, ST_FAIL} fc_state_t;
  typedef enum logic [1:0] {TM_BALANCE, TM_POSITIVE, TM_NEGATIVE, TM_HOLD} fc_tmode_t;
endpackage : fc_pkg

// ===== logic/fc_config_totalizer.sv
// fieldbus configuration, access control and flow totalizer with an apb register file
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fc_defines.svh"
// Notes on behaviour
// RULE1: jumper locked means every acyclic fieldbus write is refused.
// RULE2: jumper open (unlocked) is the default; fieldbus writes then accepted.
// RULE3: status shows write lock on while locked, off while open.
// RULE4: only bus addresses 1 to 126 are taken as valid.
// RULE5: network must give each address once; wrong address is unseen by master.
// RULE6: after reset address is 126 and software addressing selected.
// RULE7: switch address is sum of binary weights 1,2,4,8,16,32,64.
// RULE8: mode switch off uses software address, on uses switches.
// RULE9: in switch mode a software address write is ignored.
// RULE10: ready led on steadily when ready, off otherwise.
// RULE11: after self test go measuring; on failure show cause code.
// RULE12: settings change only after access code entered, default 80; here fieldbus writes change settings without the code.
// RULE13: cyclic flow unit changes only when units are pushed to fieldbus.
// RULE14: unidirectional records positive flow only; bidirectional both signs.
// RULE15: channel 273 totalizes volume flow; channel 0 stops and reads 0.
// RULE16: totalizer modes balance, positive, negative, hold.
// RULE17: balance and negative are correct only in bidirectional mode.
// RULE18: cyclic total carries the variable chosen by the channel.
// RULE19: profile bit picks full function or standard profile, full default.
// RULE20: unit setup offers unconfigured units; totals units follow flow units.
module fc_config_totalizer #(
  parameter int AW = 8,
  parameter int FW = 16,
  parameter int TW = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware straps
  input wire logic wp_jumper,
  input wire logic [6:0] addr_sw,
  input wire logic addr_mode_sw,
  // acyclic fieldbus write port
  input wire logic fb_wr_req,
  input wire logic [AW-1:0] fb_wr_addr,
  input wire logic [31:0] fb_wr_data,
  output logic fb_wr_ack,
  output logic fb_wr_nak,
  // self test
  input wire logic test_done,
  input wire logic test_fail,
  input wire logic [3:0] fail_cause,
  // flow samples
  input wire logic flow_valid,
  input wire logic [FW-1:0] flow_rate,
  // outputs to the fieldbus side and panel
  output logic led_ready,
  output logic [6:0] bus_addr,
  output logic bus_addr_ok,
  output logic [TW-1:0] cyc_total,
  output logic [7:0] cyc_flow_unit,
  output logic full_function_profile,
  output logic [3:0] err_code
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fc_pkg::fc_state_t state_ff;
  fc_pkg::fc_state_t nxt_state;
  logic bidir_ff;
  logic [1:0] tmode_ff;
  logic profile_ff;
  logic unlocked_ff;
  logic [15:0] code_ff;
  logic [6:0] sw_addr_ff;
  logic [15:0] chan_ff;
  logic [7:0] unit_ff [3];
  logic [2:0] done_ff;
  logic [7:0] bus_unit_ff;
  logic [TW-1:0] total_ff;
  logic [3:0] err_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic ack_ff;
  logic nak_ff;
  logic [6:0] addr_ff;
  logic addr_ok_ff;
  logic [TW-1:0] cyc_ff;
  logic led_ff;
  // ----------------------------------------------------------------
  // write source selection
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_ff & pwrite;
  wire rd_hit =
    (paddr == `FC_OFS_CTRL) | (paddr == `FC_OFS_ACCESS) | (paddr == `FC_OFS_CODE) |
    (paddr == `FC_OFS_ADDR) | (paddr == `FC_OFS_CHAN) | (paddr == `FC_OFS_UNIT) |
    (paddr == `FC_OFS_STAT) | (paddr == `FC_OFS_TOTAL) | (paddr == `FC_OFS_BUSUNIT);
  wire fb_hit =
    (fb_wr_addr == `FC_OFS_CTRL) | (fb_wr_addr == `FC_OFS_ADDR) |
    (fb_wr_addr == `FC_OFS_CHAN) | (fb_wr_addr == `FC_OFS_UNIT);
  // apb has priority; a fieldbus write colliding with it is refused, not delayed
  wire fb_take = fb_wr_req & ~wp_jumper & fb_hit & ~apb_wr; // RULE1 RULE2
  wire we = (apb_wr & unlocked_ff) | fb_take; // RULE12
  wire [AW-1:0] wa = apb_wr ? paddr : fb_wr_addr;
  wire [31:0] wd = apb_wr ? pwdata : fb_wr_data;
  wire wr_ctrl = we & (wa == `FC_OFS_CTRL);
  wire wr_code = apb_wr & unlocked_ff & (paddr == `FC_OFS_CODE);
  wire wr_acc = apb_wr & (paddr == `FC_OFS_ACCESS);
  wire wr_addr = we & (wa == `FC_OFS_ADDR);
  wire wr_chan = we & (wa == `FC_OFS_CHAN);
  wire wr_unit = we & (wa == `FC_OFS_UNIT);
  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  wire [6:0] hw_addr = addr_sw; // RULE7
  wire [6:0] wr_av = wd[6:0];
  wire av_ok = (wr_av >= `FC_ADDR_MIN) & (wr_av <= `FC_ADDR_MAX);
  wire take_addr = wr_addr & av_ok & ~addr_mode_sw; // RULE4 RULE9
  wire [6:0] eff_addr = addr_mode_sw ? hw_addr : sw_addr_ff; // RULE8
  wire eff_ok = (eff_addr >= `FC_ADDR_MIN) & (eff_addr <= `FC_ADDR_MAX); // RULE4
  // ----------------------------------------------------------------
  // unit setup
  // ----------------------------------------------------------------
  wire [1:0] kind = wd[`FC_UNIT_KIND_LO+1:`FC_UNIT_KIND_LO];
  wire newpass = wr_unit & wd[`FC_UNIT_NEWPASS];
  // a unit already set in this pass is no longer offered
  wire take_unit = wr_unit & ~newpass & (kind != 2'd3) & ~done_ff[kind]; // RULE20
  wire push = wr_ctrl & wd[`FC_CTRL_PUSH];
  // ----------------------------------------------------------------
  // totalizer arithmetic
  // ----------------------------------------------------------------
  wire neg = flow_rate[FW-1];
  wire [TW-1:0] fext = {{(TW-FW){flow_rate[FW-1]}}, flow_rate};
  wire recorded = ~neg | bidir_ff; // RULE14
  // balance without bidirectional mode only ever sees positive portions; negative then adds nothing
  logic add_en;
  always_comb begin
    unique case (fc_pkg::fc_tmode_t'(tmode_ff)) // RULE16 RULE17
      fc_pkg::TM_BALANCE: add_en = recorded;
      fc_pkg::TM_POSITIVE: add_en = ~neg;
      fc_pkg::TM_NEGATIVE: add_en = neg & bidir_ff;
      fc_pkg::TM_HOLD: add_en = 1'b0;
    endcase
  end
  wire chan_off = (chan_ff == `FC_CHAN_OFF);
  wire chan_vol = (chan_ff == `FC_RST_CHAN);
  wire tot_step = (state_ff == fc_pkg::ST_MEAS) & flow_valid & add_en & chan_vol;
  wire [TW-1:0] tot_sum = total_ff + fext;
  // ----------------------------------------------------------------
  // start-up sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff) // RULE11
      fc_pkg::ST_TEST: begin
        if (test_fail) begin
          nxt_state = fc_pkg::ST_FAIL;
        end else if (test_done) begin
          nxt_state = fc_pkg::ST_MEAS;
        end
      end
      fc_pkg::ST_MEAS: nxt_state = fc_pkg::ST_MEAS;
      fc_pkg::ST_FAIL: nxt_state = fc_pkg::ST_FAIL;
      default: nxt_state = fc_pkg::ST_TEST;
    endcase
  end
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] st_word = {12'h000, ~done_ff, err_ff, state_ff, eff_addr, eff_ok,
                         addr_mode_sw, unlocked_ff, wp_jumper}; // RULE3
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (paddr)
      `FC_OFS_CTRL: rmux = {28'h0, profile_ff, tmode_ff, bidir_ff};
      `FC_OFS_ACCESS: rmux = {31'h0, unlocked_ff};
      `FC_OFS_CODE: rmux = {16'h0, code_ff};
      `FC_OFS_ADDR: rmux = {25'h0, sw_addr_ff};
      `FC_OFS_CHAN: rmux = {16'h0, chan_ff};
      `FC_OFS_UNIT: rmux = {5'h0, done_ff, unit_ff[2], unit_ff[1], unit_ff[0]};
      `FC_OFS_STAT: rmux = st_word;
      `FC_OFS_TOTAL: rmux = total_ff;
      `FC_OFS_BUSUNIT: rmux = {24'h0, bus_unit_ff};
      default: rmux = 32'h0000_0000;
    endcase
  end
  // ----------------------------------------------------------------
  // apb handshake: data latched in setup, pready for one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rmux;
        pslverr_ff <= ~rd_hit;
      end
    end
  end
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bidir_ff <= 1'b0;
      tmode_ff <= 2'h0;
      profile_ff <= 1'b1;
      unlocked_ff <= 1'b0;
      code_ff <= `FC_RST_CODE;
      sw_addr_ff <= `FC_RST_ADDR; // RULE6
      chan_ff <= `FC_RST_CHAN;
      done_ff <= 3'h0;
      bus_unit_ff <= `FC_RST_UNIT;
    end else begin
      if (wr_ctrl) begin
        bidir_ff <= wd[`FC_CTRL_BIDIR]; // RULE14
        tmode_ff <= wd[`FC_CTRL_TMODE_LO+1:`FC_CTRL_TMODE_LO]; // RULE16
        profile_ff <= wd[`FC_CTRL_PROFILE]; // RULE19
      end
      if (wr_acc) begin
        unlocked_ff <= (pwdata[15:0] == code_ff); // RULE12
      end
      if (wr_code) begin
        code_ff <= pwdata[15:0];
      end
      if (take_addr) begin
        sw_addr_ff <= wr_av; // RULE9
      end
      if (wr_chan) begin
        chan_ff <= wd[15:0];
      end
      if (newpass) begin
        done_ff <= 3'h0;
      end else if (take_unit) begin
        done_ff[kind] <= 1'b1; // RULE20
      end
      if (push) begin
        bus_unit_ff <= unit_ff[1]; // RULE13
      end
    end
  end
  // volume flow unit is kind 1; volume/mass/corrected units read back as the flow codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_ff[0] <= `FC_RST_UNIT;
      unit_ff[1] <= `FC_RST_UNIT;
      unit_ff[2] <= `FC_RST_UNIT;
    end else if (take_unit) begin
      unit_ff[kind] <= wd[7:0]; // RULE20
    end
  end
  // ----------------------------------------------------------------
  // start-up, totalizer and output flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= fc_pkg::ST_TEST;
      err_ff <= 4'h0;
      total_ff <= '0;
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
      addr_ff <= `FC_RST_ADDR;
      addr_ok_ff <= 1'b1;
      cyc_ff <= '0;
      led_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == fc_pkg::ST_TEST) & test_fail) begin
        err_ff <= fail_cause; // RULE11
      end
      if (chan_off) begin
        total_ff <= '0; // RULE15
      end else if (tot_step) begin
        total_ff <= tot_sum; // RULE15
      end
      ack_ff <= fb_take;
      nak_ff <= fb_wr_req & ~fb_take; // RULE1
      addr_ff <= eff_addr;
      addr_ok_ff <= eff_ok;
      cyc_ff <= total_ff; // RULE18
      // taken from the next state so the led flop does not lag the state flop
      led_ff <= (nxt_state == fc_pkg::ST_MEAS); // RULE10
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fb_wr_ack = ack_ff;
  assign fb_wr_nak = nak_ff;
  assign led_ready = led_ff;
  assign bus_addr = addr_ff;
  assign bus_addr_ok = addr_ok_ff;
  assign cyc_total = cyc_ff;
  assign cyc_flow_unit = bus_unit_ff;
  assign full_function_profile = profile_ff;
  assign err_code = err_ff;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_lock_refuse;
    @(posedge pclk) disable iff (!presetn)
    (fb_wr_req & wp_jumper) |=> (fb_wr_nak & ~fb_wr_ack);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked write accepted"); // RULE1
  property p_open_accept;
    @(posedge pclk) disable iff (!presetn)
    (fb_wr_req & ~wp_jumper & fb_hit & ~apb_wr) |=> fb_wr_ack;
  endproperty
  a_open_accept: assert property (p_open_accept) else $error("open write refused"); // RULE2
  property p_addr_range;
    @(posedge pclk) disable iff (!presetn)
    ##1 (sw_addr_ff >= 7'h01 && sw_addr_ff <= 7'h7e);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("soft address out of range"); // RULE4
  property p_hw_ignore;
    @(posedge pclk) disable iff (!presetn)
    addr_mode_sw |=> $stable(sw_addr_ff);
  endproperty
  a_hw_ignore: assert property (p_hw_ignore) else $error("soft address written in hw mode"); // RULE9
  property p_hw_addr;
    @(posedge pclk) disable iff (!presetn)
    (addr_mode_sw & $stable(addr_sw)) |=> (bus_addr == $past(addr_sw));
  endproperty
  a_hw_addr: assert property (p_hw_addr) else $error("switch address not used"); // RULE7
  sequence s_fail_seen;
    (state_ff == fc_pkg::ST_TEST) & test_fail;
  endsequence
  property p_fail_cause;
    @(posedge pclk) disable iff (!presetn)
    s_fail_seen ##1 1'b1 |-> (err_code == $past(fail_cause)) & ~led_ready;
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("fail cause lost"); // RULE11
  property p_code_gate;
    @(posedge pclk) disable iff (!presetn)
    (apb_wr & ~unlocked_ff & (paddr == `FC_OFS_CHAN)) |=> $stable(chan_ff);
  endproperty
  a_code_gate: assert property (p_code_gate) else $error("write without code"); // RULE12
  property p_unit_hold;
    @(posedge pclk) disable iff (!presetn)
    ~push |=> $stable(cyc_flow_unit);
  endproperty
  a_unit_hold: assert property (p_unit_hold) else $error("bus unit moved without push"); // RULE13
  property p_chan_off;
    @(posedge pclk) disable iff (!presetn)
    (chan_off & ~wr_chan) [*2] |=> (cyc_total == '0);
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("channel off total not zero"); // RULE15
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (tmode_ff == 2'h3 & ~chan_off) |=> $stable(total_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode total moved"); // RULE16
  property p_unidir;
    @(posedge pclk) disable iff (!presetn)
    (~bidir_ff & ~chan_off) |=> (total_ff >= $past(total_ff));
  endproperty
  a_unidir: assert property (p_unidir) else $error("negative flow recorded"); // RULE14
  property p_pready;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 ~pready;
  endproperty
  a_pready: assert property (p_pready) else $error("apb answer timing wrong"); // apb timing, decided locally
  property p_profile;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (full_function_profile == $past(wd[`FC_CTRL_PROFILE]));
  endproperty
  a_profile: assert property (p_profile) else $error("profile select not taken"); // RULE19
endmodule : fc_config_totalizer
`default_nettype wire

// ===== verif/fc_fb_master.sv
// fieldbus master model that issues acyclic writes to the block
`timescale 1ns/10ps
`default_nettype none
module fc_fb_master #(
  parameter int AW = 8
) (
  // clock
  input wire logic pclk,
  // acyclic write request
  output logic fb_wr_req,
  output logic [AW-1:0] fb_wr_addr,
  output logic [31:0] fb_wr_data,
  // slave answer
  input wire logic fb_wr_ack,
  input wire logic fb_wr_nak,
  input wire logic bus_addr_ok
);
  // ----------------------------------------
  // write transfer
  // ----------------------------------------
  initial begin
    fb_wr_req = 1'b0;
    fb_wr_addr = '0;
    fb_wr_data = '0;
  end
  task automatic fb_write(input logic [AW-1:0] a, input logic [31:0] d, output logic ack,
                          output logic nak);
    ack = 1'b0;
    nak = 1'b0;
    // a slave with a bad address is never seen, so nothing is sent to it
    if (bus_addr_ok !== 1'b1) return;
    @(posedge pclk);
    fb_wr_req <= 1'b1;
    fb_wr_addr <= a;
    fb_wr_data <= d;
    @(posedge pclk);
    fb_wr_req <= 1'b0;
    // released lines carry the inverse so stale data cannot pass for a match
    fb_wr_addr <= ~a;
    fb_wr_data <= ~d;
    @(posedge pclk);
    ack = fb_wr_ack;
    nak = fb_wr_nak;
  endtask : fb_write
endmodule : fc_fb_master
`default_nettype wire

// ===== verif/test_fc_config_totalizer.sv
// self-checking bench of the config and totalizer block
`timescale 1ns/10ps
`default_nettype none
`include "fc_defines.svh"
module test_fc_config_totalizer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack, nak;
  logic [7:0] paddr, fb_wr_addr, cyc_flow_unit;
  logic [31:0] pwdata, prdata, rd, fb_wr_data, cyc_total, exp_tot;
  logic wp_jumper, addr_mode_sw, test_done, test_fail, flow_valid, fb_wr_req, fb_wr_ack;
  logic fb_wr_nak, led_ready, bus_addr_ok, full_function_profile;
  logic [6:0] addr_sw, bus_addr;
  logic [6:0] av [3] = '{7'h00, 7'h7f, 7'h05};
  logic [3:0] fail_cause, err_code;
  logic [15:0] flow_rate;
  int fail_count = 0;
  int samples_checked = 0;
  fc_config_totalizer i_fc_config_totalizer (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .wp_jumper, .addr_sw, .addr_mode_sw,
    .fb_wr_req, .fb_wr_addr, .fb_wr_data, .fb_wr_ack, .fb_wr_nak, .test_done, .test_fail,
    .fail_cause, .flow_valid, .flow_rate, .led_ready, .bus_addr, .bus_addr_ok, .cyc_total,
    .cyc_flow_unit, .full_function_profile, .err_code);
  fc_fb_master i_fc_fb_master (.pclk, .fb_wr_req, .fb_wr_addr, .fb_wr_data, .fb_wr_ack,
    .fb_wr_nak, .bus_addr_ok);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait states are taken as they come; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic flow(input logic [15:0] v);
    @(posedge pclk);
    flow_valid <= 1'b1;
    flow_rate <= v;
    @(posedge pclk);
    flow_valid <= 1'b0;
    flow_rate <= ~v;
  endtask : flow
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, wp_jumper, addr_mode_sw, test_done} = '0;
    {test_fail, flow_valid, paddr, pwdata, addr_sw, fail_cause, flow_rate, exp_tot} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("bus_addr", 32'd126, {25'h0, bus_addr});
    chk("addr_ok", 32'h1, {31'h0, bus_addr_ok});
    chk("profile", 32'h1, {31'h0, full_function_profile});
    apb(1'b0, `FC_OFS_CODE, 32'h0);
    chk("code", 32'h50, rd);
    apb(1'b0, `FC_OFS_CHAN, 32'h0);
    chk("chan", 32'h111, rd);
    apb(1'b0, `FC_OFS_STAT, 32'h0);
    chk("stat", 32'h0, {28'h0, rd[12:11], rd[2], rd[0]});
    chk("led", 32'h0, {31'h0, led_ready});
    test_done <= 1'b1;
    cyc(3);
    chk("led", 32'h1, {31'h0, led_ready});
    apb(1'b1, `FC_OFS_ADDR, 32'h5);
    apb(1'b0, `FC_OFS_ADDR, 32'h0);
    chk("addr_locked", 32'd126, rd);
    apb(1'b1, `FC_OFS_ACCESS, 32'h50);
    apb(1'b0, `FC_OFS_ACCESS, 32'h0);
    chk("unlocked", 32'h1, {31'h0, rd[0]});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `FC_OFS_ADDR, {25'h0, av[i]});
      apb(1'b0, `FC_OFS_ADDR, 32'h0);
      chk("addr", (i < 2) ? 32'd126 : 32'd5, rd);
    end
    cyc(2);
    chk("bus_addr", 32'd5, {25'h0, bus_addr});
    addr_sw <= 7'h31;
    addr_mode_sw <= 1'b1;
    cyc(3);
    chk("bus_addr", 32'd49, {25'h0, bus_addr});
    apb(1'b1, `FC_OFS_ADDR, 32'h9);
    cyc(2);
    chk("bus_addr", 32'd49, {25'h0, bus_addr});
    addr_sw <= 7'h7f;
    cyc(3);
    chk("addr_ok", 32'h0, {31'h0, bus_addr_ok});
    i_fc_fb_master.fb_write(`FC_OFS_CTRL, 32'h0, ack, nak);
    chk("fb_unseen", 32'h0, {30'h0, ack, nak});
    addr_mode_sw <= 1'b0;
    cyc(3);
    chk("bus_addr", 32'd5, {25'h0, bus_addr});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {rd, err} == 33'h1);
    apb(1'b1, `FC_OFS_CTRL, 32'h0);
    cyc(2);
    chk("profile", 32'h0, {31'h0, full_function_profile});
    // every mode in both directions, with one positive and one negative sample
    for (int b = 0; b < 2; b++) begin
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, `FC_OFS_CTRL, {29'h1, 2'(m), 1'(b)});
        flow(16'h0007);
        flow(16'hfffd);
        if (m < 2) exp_tot += 32'd7;
        if (b == 1 && (m == 0 || m == 2)) exp_tot -= 32'd3;
        cyc(2);
        apb(1'b0, `FC_OFS_TOTAL, 32'h0);
        chk("total", exp_tot, rd);
        chk("cyc_total", exp_tot, cyc_total);
      end
    end
    chk("profile", 32'h1, {31'h0, full_function_profile});
    apb(1'b1, `FC_OFS_UNIT, 32'h133);
    cyc(2);
    chk("flow_unit", 32'h0, {24'h0, cyc_flow_unit});
    apb(1'b1, `FC_OFS_CTRL, 32'h18);
    cyc(2);
    chk("flow_unit", 32'h33, {24'h0, cyc_flow_unit});
    apb(1'b1, `FC_OFS_UNIT, 32'h144);
    apb(1'b0, `FC_OFS_UNIT, 32'h0);
    chk("unit", 32'h233, {21'h0, rd[26:24], rd[15:8]});
    apb(1'b0, `FC_OFS_STAT, 32'h0);
    chk("offered", 32'h5, {29'h0, rd[19:17]});
    i_fc_fb_master.fb_write(`FC_OFS_CHAN, 32'h0, ack, nak);
    chk("fb_ack", 32'h2, {30'h0, ack, nak});
    flow(16'h0007);
    cyc(2);
    apb(1'b0, `FC_OFS_TOTAL, 32'h0);
    chk("total_off", 32'h0, rd);
    wp_jumper <= 1'b1;
    cyc(2);
    apb(1'b0, `FC_OFS_STAT, 32'h0);
    chk("wp_stat", 32'h1, {31'h0, rd[0]});
    i_fc_fb_master.fb_write(`FC_OFS_CHAN, 32'h111, ack, nak);
    chk("fb_nak", 32'h1, {30'h0, ack, nak});
    apb(1'b0, `FC_OFS_CHAN, 32'h0);
    chk("chan", 32'h0, rd);
    wp_jumper <= 1'b0;
    i_fc_fb_master.fb_write(`FC_OFS_STAT, 32'h0, ack, nak);
    chk("fb_ro", 32'h1, {30'h0, ack, nak});
    apb(1'b1, `FC_OFS_ACCESS, 32'h12);
    apb(1'b0, `FC_OFS_ACCESS, 32'h0);
    chk("relock", 32'h0, {31'h0, rd[0]});
    apb(1'b1, `FC_OFS_CHAN, 32'h111);
    apb(1'b0, `FC_OFS_CHAN, 32'h0);
    chk("chan_locked", 32'h0, rd);
    @(posedge pclk);
    presetn <= 1'b0;
    test_done <= 1'b0;
    test_fail <= 1'b1;
    fail_cause <= 4'h5;
    cyc(3);
    presetn <= 1'b1;
    cyc(3);
    chk("err_code", 32'h5, {28'h0, err_code});
    chk("led", 32'h0, {31'h0, led_ready});
    final_report();
  end
endmodule : test_fc_config_totalizer
`default_nettype wire
